// >>> hdl/csdc_regs.svh
// csdc_regs.svh: constants for the clock source and divider control block
// assumes a 40 MHz mclk and a 6-bit rc trim value
`ifndef CSDC_REGS_SVH
`define CSDC_REGS_SVH

// ------------------------------------------------------------
// clock rate
// ------------------------------------------------------------
`define CSDC_MCLK_PERIOD_NS 25

// ------------------------------------------------------------
// wake-up delay: osc cycles, then a least time in ns
// ------------------------------------------------------------
`define CSDC_XTAL_WAKE_OSC 10'h03e0
`define CSDC_OTHER_WAKE_OSC 10'h00e0
`define CSDC_WAKE_MIN_NS 60000
`define CSDC_WAKE_US_CYC \
    ((`CSDC_WAKE_MIN_NS + `CSDC_MCLK_PERIOD_NS - 1) / `CSDC_MCLK_PERIOD_NS)

// ------------------------------------------------------------
// divider, machine cycle, trim
// ------------------------------------------------------------
`define CSDC_CDIV_W 8
`define CSDC_CDIV_MAX_RATIO 510
`define CSDC_CPU_PER_MACH 2
`define CSDC_TRIM_W 6
`define CSDC_TRIM_EN_RST 1'h0
`define CSDC_LP_RST 1'h0

`endif

// >>> hdl/csdc_pkg.sv
// csdc_pkg: types for the clock source and divider control block
// assumes csdc_regs.svh is on the include path
`include "csdc_regs.svh"

package csdc_pkg;

    // ------------------------------------------------------------
    // oscillator source and crystal range from flash configuration
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_WDT  = 2'h0,
        SRC_RC   = 2'h1,
        SRC_XTAL = 2'h2,
        SRC_EXT  = 2'h3
    } csdc_src_t;

    // low 20k-100k, medium 100k-4M, high 4M-18M
    typedef enum logic [1:0] {
        RNG_LOW  = 2'h0,
        RNG_MED  = 2'h1,
        RNG_HIGH = 2'h2
    } csdc_range_t;

    typedef struct packed {
        csdc_src_t src;
        csdc_range_t range;
    } csdc_cfg_t;

    typedef struct packed {
        logic clock_out_enable;
        logic [`CSDC_TRIM_W-1:0] value;
    } csdc_trim_t;

    // ------------------------------------------------------------
    // wake-up sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OSC = 3'h1,
        ST_US  = 3'h2,
        ST_RUN = 3'h4
    } csdc_state_t;

endpackage : csdc_pkg

// >>> hdl/csdc_divider.sv
// csdc_divider: divides osc ticks into cpu clock ticks
// assumes osc_tick is a one-cycle pulse on mclk
`timescale 1ns/10ps
`include "csdc_regs.svh"

module csdc_divider #(
    parameter int CDIV_W = `CSDC_CDIV_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic osc_tick,
    input wire logic [CDIV_W-1:0] cpu_clock_divider,
    // result
    output logic cpu_tick
);

    logic [CDIV_W:0] cnt_ff;
    logic [CDIV_W:0] nxt_cnt;
    logic [CDIV_W-1:0] cur_ff;
    logic [CDIV_W-1:0] nxt_cur;
    logic tick_ff;
    logic nxt_tick;
    logic [CDIV_W:0] last;

    // ------------------------------------------------------------
    // period of 1 for zero, else twice the setting
    // ------------------------------------------------------------
    always_comb
    begin
        last = (cur_ff == '0) ? '0 : ({cur_ff, 1'b0} - {{CDIV_W{1'b0}}, 1'b1});
        nxt_cnt = cnt_ff;
        nxt_cur = cur_ff;
        nxt_tick = 1'b0;
        if (!run)
        begin
            nxt_cnt = '0;
            nxt_cur = cpu_clock_divider;
        end
        else if (osc_tick)
        begin
            if (cnt_ff >= last)
            begin
                nxt_cnt = '0;
                nxt_tick = 1'b1;
                // new ratio only at a period boundary
                nxt_cur = cpu_clock_divider;
            end
            else
            begin
                nxt_cnt = cnt_ff + {{CDIV_W{1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff <= '0;
            cur_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            cur_ff <= nxt_cur;
            tick_ff <= nxt_tick;
        end
    end

    assign cpu_tick = tick_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_div_zero_pass: assert property (@(posedge mclk) disable iff (rst)
        (run && osc_tick && cur_ff == '0) |=> tick_ff)
        else $error("zero divider did not pass osc tick");

    a_div_no_early: assert property (@(posedge mclk) disable iff (rst)
        (run && osc_tick && cur_ff != '0 && cnt_ff == '0) |=> !tick_ff)
        else $error("divider ticked before period end");

endmodule : csdc_divider

// >>> hdl/csdc_clock_ctrl.sv
// csdc_clock_ctrl: oscillator select, wake-up delay, cpu and peripheral clock ticks
// assumes oscillator inputs are asynchronous square waves well below mclk/2
//
// Behaviour
// - a machine cycle spans exactly two cpu clock cycles
// - osc clock is chosen from one of four sources
// - peripheral clock runs at half the cpu clock frequency
// - 6-bit writable rc trim, loaded from factory value during power-on reset
// - source selection comes from flash configuration, not run-time writes
// - crystal offers low, medium and high frequency ranges
// - clock out drives only if enabled, not crystal source, rtc off crystal
// - clock out frequency is half the cpu clock
// - crystal wake-up holds cpu clock 992 osc cycles plus 60-100 us
// - other sources wake-up holds 224 osc cycles plus 60-100 us
// - programmable divider derives cpu clock, ratio up to 510
// - divider may change any time without disturbing execution
// - low power clock bit clears on every reset; software sets it
// - watchdog oscillator selectable as system clock source
// - only power-on reset reloads trim; other resets leave it
`timescale 1ns/10ps
`include "csdc_regs.svh"

module csdc_clock_ctrl #(
    parameter int CDIV_W = `CSDC_CDIV_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic por,
    // flash configuration
    input wire csdc_pkg::csdc_cfg_t cfg,
    input wire logic [`CSDC_TRIM_W-1:0] factory_trim,
    // oscillator inputs
    input wire logic wdt_osc,
    input wire logic rc_osc_clock,
    input wire logic xtal_in_clock_pin,
    // software controls
    input wire logic [CDIV_W-1:0] cpu_clock_divider,
    input wire logic trim_we,
    input wire csdc_pkg::csdc_trim_t trim_wdata,
    input wire logic lp_we,
    input wire logic lp_wdata,
    input wire logic rtc_on_xtal,
    // clock ticks
    output logic cpu_tick,
    output logic mach_cycle,
    output logic pclk,
    output logic cpu_run,
    // clock out pin
    output logic xtal_out_clock_pin,
    output logic xtal_out_clock_pin_oe,
    // status
    output logic xtal_amp_en,
    output csdc_pkg::csdc_range_t xtal_range,
    output csdc_pkg::csdc_trim_t trim_q,
    output logic low_power_clock_bit
);

    localparam logic [11:0] US_LAST = 12'(`CSDC_WAKE_US_CYC - 1);

    // ------------------------------------------------------------
    // oscillator synchronisers and source select
    // ------------------------------------------------------------
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] sync3_ff;
    logic [2:0] arm_ff;
    logic [1:0] sel;
    logic osc_tick;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            sync3_ff <= 3'h0;
            arm_ff <= 3'h0;
        end
        else
        begin
            sync1_ff <= {xtal_in_clock_pin, rc_osc_clock, wdt_osc};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            arm_ff <= {arm_ff[1:0], 1'b1};
        end
    end

    csdc_pkg::csdc_state_t state_ff;
    csdc_pkg::csdc_state_t nxt_state;
    csdc_pkg::csdc_cfg_t cfg_ff;
    csdc_pkg::csdc_cfg_t nxt_cfg;
    logic cap_ff;
    logic nxt_cap;
    logic [9:0] osc_cnt_ff;
    logic [9:0] nxt_osc_cnt;
    logic [11:0] us_cnt_ff;
    logic [11:0] nxt_us_cnt;
    logic [9:0] osc_last;
    logic is_xtal;

    always_comb
    begin
        unique case (cfg_ff.src)
            csdc_pkg::SRC_WDT: sel = 2'h0;
            csdc_pkg::SRC_RC: sel = 2'h1;
            csdc_pkg::SRC_XTAL: sel = 2'h2;
            csdc_pkg::SRC_EXT: sel = 2'h2;
        endcase
        // edge flop holds real pin data only from the third cycle: no false edge
        osc_tick = cap_ff & arm_ff[2] & sync2_ff[sel] & ~sync3_ff[sel];
    end

    // ------------------------------------------------------------
    // configuration capture and wake-up sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        is_xtal = (cfg_ff.src == csdc_pkg::SRC_XTAL);
        osc_last = is_xtal ? (`CSDC_XTAL_WAKE_OSC - 10'h001)
                           : (`CSDC_OTHER_WAKE_OSC - 10'h001);
        nxt_state = state_ff;
        nxt_cfg = cfg_ff;
        nxt_cap = cap_ff;
        nxt_osc_cnt = osc_cnt_ff;
        nxt_us_cnt = us_cnt_ff;
        unique case (state_ff)
            csdc_pkg::ST_OSC:
            begin
                if (!cap_ff)
                begin
                    // taken once after reset release only
                    nxt_cfg = cfg;
                    nxt_cap = 1'b1;
                end
                else if (osc_tick)
                begin
                    if (osc_cnt_ff == osc_last)
                    begin
                        nxt_osc_cnt = 10'h000;
                        nxt_state = csdc_pkg::ST_US;
                    end
                    else
                    begin
                        nxt_osc_cnt = osc_cnt_ff + 10'h001;
                    end
                end
            end
            csdc_pkg::ST_US:
            begin
                if (us_cnt_ff == US_LAST)
                begin
                    nxt_state = csdc_pkg::ST_RUN;
                end
                else
                begin
                    nxt_us_cnt = us_cnt_ff + 12'h001;
                end
            end
            csdc_pkg::ST_RUN:
            begin
                nxt_state = csdc_pkg::ST_RUN;
            end
            default:
            begin
                nxt_state = csdc_pkg::ST_OSC;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= csdc_pkg::ST_OSC;
            cfg_ff <= '0;
            cap_ff <= 1'b0;
            osc_cnt_ff <= 10'h000;
            us_cnt_ff <= 12'h000;
        end
        else
        begin
            state_ff <= nxt_state;
            cfg_ff <= nxt_cfg;
            cap_ff <= nxt_cap;
            osc_cnt_ff <= nxt_osc_cnt;
            us_cnt_ff <= nxt_us_cnt;
        end
    end

    // ------------------------------------------------------------
    // cpu clock divider
    // ------------------------------------------------------------
    logic div_tick;

    csdc_divider #(
        .CDIV_W(CDIV_W)
    ) u_div (
        .mclk(mclk),
        .rst(rst),
        .run(state_ff == csdc_pkg::ST_RUN),
        .osc_tick(osc_tick),
        .cpu_clock_divider(cpu_clock_divider),
        .cpu_tick(div_tick)
    );

    // ------------------------------------------------------------
    // machine cycle, peripheral clock, clock out
    // ------------------------------------------------------------
    logic phase_ff, nxt_phase;
    logic mach_ff, nxt_mach;
    logic pclk_ff, nxt_pclk;
    logic co_ff, nxt_co;
    logic oe_ff, nxt_oe;
    logic run_ff, nxt_run;
    logic amp_ff, nxt_amp;
    csdc_pkg::csdc_trim_t trim_ff;
    csdc_pkg::csdc_trim_t nxt_trim;

    always_comb
    begin
        nxt_phase = phase_ff ^ div_tick;
        nxt_mach = div_tick & phase_ff;
        nxt_pclk = pclk_ff ^ div_tick;
        nxt_oe = trim_ff.clock_out_enable & ~is_xtal & ~rtc_on_xtal;
        nxt_co = oe_ff ? (co_ff ^ div_tick) : 1'b0;
        nxt_run = (state_ff == csdc_pkg::ST_RUN);
        nxt_amp = cap_ff & is_xtal;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            phase_ff <= 1'b0;
            mach_ff <= 1'b0;
            pclk_ff <= 1'b0;
            co_ff <= 1'b0;
            oe_ff <= 1'b0;
            run_ff <= 1'b0;
            amp_ff <= 1'b0;
        end
        else
        begin
            phase_ff <= nxt_phase;
            mach_ff <= nxt_mach;
            pclk_ff <= nxt_pclk;
            co_ff <= nxt_co;
            oe_ff <= nxt_oe;
            run_ff <= nxt_run;
            amp_ff <= nxt_amp;
        end
    end

    // ------------------------------------------------------------
    // trim register: power-on reset only
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_trim = trim_ff;
        if (por)
        begin
            nxt_trim.value = factory_trim;
            nxt_trim.clock_out_enable = `CSDC_TRIM_EN_RST;
        end
        else if (trim_we)
        begin
            nxt_trim = trim_wdata;
        end
    end

    always_ff @(posedge mclk)
    begin
        trim_ff <= nxt_trim;
    end

    // ------------------------------------------------------------
    // low power clock bit
    // ------------------------------------------------------------
    logic lp_ff, nxt_lp;

    always_comb
    begin
        nxt_lp = lp_we ? lp_wdata : lp_ff;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            lp_ff <= `CSDC_LP_RST;
        end
        else
        begin
            lp_ff <= nxt_lp;
        end
    end

    assign cpu_tick = div_tick;
    assign mach_cycle = mach_ff;
    assign pclk = pclk_ff;
    assign cpu_run = run_ff;
    assign xtal_out_clock_pin = co_ff;
    assign xtal_out_clock_pin_oe = oe_ff;
    assign xtal_amp_en = amp_ff;
    assign xtal_range = cfg_ff.range;
    assign trim_q = trim_ff;
    assign low_power_clock_bit = lp_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_mach_two_cpu: assert property (@(posedge mclk) disable iff (rst)
        mach_ff |-> $past(div_tick) && !phase_ff)
        else $error("machine cycle not on second cpu tick");

    a_pclk_half: assert property (@(posedge mclk) disable iff (rst)
        (pclk_ff != $past(pclk_ff)) |-> $past(div_tick))
        else $error("peripheral clock moved without cpu tick");

    a_clkout_gate: assert property (@(posedge mclk) disable iff (rst)
        oe_ff |-> $past(trim_ff.clock_out_enable && !is_xtal && !rtc_on_xtal))
        else $error("clock out driven while not allowed");

    a_clkout_half: assert property (@(posedge mclk) disable iff (rst)
        (co_ff != $past(co_ff)) |-> ($past(div_tick) || !$past(oe_ff)))
        else $error("clock out toggled without cpu tick");

    a_wake_osc_count: assert property (@(posedge mclk) disable iff (rst)
        (state_ff == csdc_pkg::ST_OSC && nxt_state == csdc_pkg::ST_US)
        |-> osc_cnt_ff == (is_xtal ? 10'h03df : 10'h00df))
        else $error("wake osc count wrong");

    a_wake_us_hold: assert property (@(posedge mclk) disable iff (rst)
        $rose(run_ff) |-> $past(us_cnt_ff, 2) == US_LAST)
        else $error("wake time not met");

    a_cpu_held: assert property (@(posedge mclk) disable iff (rst)
        (state_ff != csdc_pkg::ST_RUN) |=> !div_tick)
        else $error("cpu tick during wake-up");

    a_src_frozen: assert property (@(posedge mclk) disable iff (rst)
        cap_ff |=> $stable(cfg_ff))
        else $error("source changed after capture");

    a_trim_por: assert property (@(posedge mclk)
        por |=> trim_ff.value == $past(factory_trim))
        else $error("trim not loaded on power-on");

    a_trim_hold: assert property (@(posedge mclk)
        (!por && !trim_we) |=> $stable(trim_ff))
        else $error("trim changed without write");

    a_lp_clear: assert property (@(posedge mclk)
        $past(rst) |-> !lp_ff)
        else $error("low power bit not cleared by reset");

    c_wake_done: cover property (@(posedge mclk) disable iff (rst) $rose(run_ff));
    c_clkout: cover property (@(posedge mclk) disable iff (rst) oe_ff && div_tick);
    c_div_change: cover property (@(posedge mclk) disable iff (rst)
        run_ff && cpu_clock_divider != $past(cpu_clock_divider));
    c_lp_set: cover property (@(posedge mclk) disable iff (rst) $rose(lp_ff));

endmodule : csdc_clock_ctrl

// >>> sim/csdc_osc_model.sv
// csdc_osc_model: free-running oscillator waves facing the clock block
// assumes each period is a whole multiple of the 25 ns mclk
`timescale 1ns/10ps

module csdc_osc_model #(
    parameter int WDT_NS = 250,
    parameter int RC_NS = 150,
    parameter int XTAL_NS = 200
) (
    // oscillator waves
    output logic wdt_osc,
    output logic rc_osc_clock,
    output logic xtal_in_clock_pin
);
    // ------------------------------------------------------------
    // waves, each phase kept off the mclk edges
    // ------------------------------------------------------------
    initial
    begin
        wdt_osc = 1'h0;
        #3;
        forever #(WDT_NS / 2.0) wdt_osc = ~wdt_osc;
    end

    initial
    begin
        rc_osc_clock = 1'h0;
        #7;
        forever #(RC_NS / 2.0) rc_osc_clock = ~rc_osc_clock;
    end

    // crystal or external wave, kept below 12 MHz so no reset pin is needed
    initial
    begin
        xtal_in_clock_pin = 1'h0;
        #11;
        forever #(XTAL_NS / 2.0) xtal_in_clock_pin = ~xtal_in_clock_pin;
    end
endmodule : csdc_osc_model

// >>> sim/clock_source_divider_control_tb_top.sv
// clock_source_divider_control_tb_top: self-checking bench for csdc_clock_ctrl
// assumes csdc_osc_model periods of 10, 6 and 8 mclk for wdt, rc and xtal
`timescale 1ns/10ps
`include "csdc_regs.svh"

module clock_source_divider_control_tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct {
        csdc_pkg::csdc_src_t src;
        csdc_pkg::csdc_range_t rng;
        logic [7:0] div_n;
        logic rtc;
        logic en;
        int per;
        int wake;
        logic oe;
    } csdc_row_t;
    csdc_row_t rows[6];
    logic mclk, rst, por, trim_we, lp_we, lp_wdata, rtc_on_xtal;
    logic wdt_osc, rc_osc_clock, xtal_in_clock_pin;
    logic cpu_tick, mach_cycle, pclk, cpu_run, xtal_amp_en, low_power_clock_bit;
    logic xtal_out_clock_pin, xtal_out_clock_pin_oe, pclk_q, pin_q;
    logic [5:0] factory_trim;
    logic [7:0] cpu_clock_divider;
    csdc_pkg::csdc_cfg_t cfg;
    csdc_pkg::csdc_trim_t trim_wdata, trim_q;
    csdc_pkg::csdc_range_t xtal_range;
    int n_fail, cmp_count, n_cyc, n_tick, n_mach, n_pclk, n_pin;

    csdc_osc_model csdc_osc_model_inst (
        .wdt_osc(wdt_osc),
        .rc_osc_clock(rc_osc_clock),
        .xtal_in_clock_pin(xtal_in_clock_pin)
    );

    csdc_clock_ctrl csdc_clock_ctrl_inst (
        .mclk(mclk), .rst(rst), .por(por), .cfg(cfg), .factory_trim(factory_trim),
        .wdt_osc(wdt_osc), .rc_osc_clock(rc_osc_clock),
        .xtal_in_clock_pin(xtal_in_clock_pin), .cpu_clock_divider(cpu_clock_divider),
        .trim_we(trim_we), .trim_wdata(trim_wdata), .lp_we(lp_we), .lp_wdata(lp_wdata),
        .rtc_on_xtal(rtc_on_xtal), .cpu_tick(cpu_tick), .mach_cycle(mach_cycle),
        .pclk(pclk), .cpu_run(cpu_run), .xtal_out_clock_pin(xtal_out_clock_pin),
        .xtal_out_clock_pin_oe(xtal_out_clock_pin_oe), .xtal_amp_en(xtal_amp_en),
        .xtal_range(xtal_range), .trim_q(trim_q), .low_power_clock_bit(low_power_clock_bit)
    );

    // ------------------------------------------------------------
    // clock and output monitor
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        n_cyc++;
        if (cpu_tick === 1'h1) n_tick++;
        if (mach_cycle === 1'h1) n_mach++;
        if (pclk !== pclk_q) n_pclk++;
        if (xtal_out_clock_pin !== pin_q) n_pin++;
        pclk_q = pclk;
        pin_q = xtal_out_clock_pin;
    end

    // ------------------------------------------------------------
    // compare and sequencing tasks
    // ------------------------------------------------------------
    task automatic chk_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        cmp_count++;
        if (got < lo || got > hi)
        begin
            n_fail++;
            $display("MISMATCH %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : chk_rng

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic wait_clk(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_clk

    task automatic do_reset(input logic p);
        rst = 1'h1;
        por = p;
        wait_clk(5);
        chk_bit(cpu_run, 1'h0, "run in reset");
        chk_bit(low_power_clock_bit, 1'h0, "lp in reset");
        rst = 1'h0;
        por = 1'h0;
        n_tick = 0;
    endtask : do_reset

    task automatic write_trim(input logic en, input logic [5:0] v);
        trim_wdata = '{clock_out_enable: en, value: v};
        trim_we = 1'h1;
        wait_clk(1);
        trim_we = 1'h0;
    endtask : write_trim

    task automatic wake(input int per, input int cnt);
        int cyc;
        int lo;
        cyc = 1;
        lo = (cnt - 1) * per + 2400;
        while (cpu_run !== 1'h1 && cyc < 20000)
        begin
            wait_clk(1);
            cyc++;
            if (cyc == lo) chk_rng(n_tick, 0, 0, "tick before wake");
        end
        if (cyc >= 20000)
        begin
            n_fail++;
            results();
        end
        chk_rng(cyc, lo, cnt * per + 2412, "wake time");
    endtask : wake

    task automatic wait_tick();
        int k;
        k = 0;
        do
        begin
            wait_clk(1);
            k++;
        end
        while (cpu_tick !== 1'h1 && k < 5000);
        if (k >= 5000)
        begin
            n_fail++;
            results();
        end
    endtask : wait_tick

    task automatic measure(input int p, input logic oe);
        wait_tick();
        wait_clk(2);
        n_cyc = 0;
        n_tick = 0;
        n_mach = 0;
        n_pclk = 0;
        n_pin = 0;
        repeat (4) wait_tick();
        wait_clk(2);
        chk_rng(n_cyc, 4 * p, 4 * p, "cpu period");
        chk_rng(n_mach, 2, 2, "machine cycles");
        chk_rng(n_pclk, 4, 4, "pclk toggles");
        chk_bit(xtal_out_clock_pin_oe, oe, "clock out enable");
        chk_rng(n_pin, oe ? 4 : 0, oe ? 4 : 0, "clock out toggles");
        if (!oe) chk_bit(xtal_out_clock_pin, 1'h0, "clock out idle");
    endtask : measure

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rows[0] = '{csdc_pkg::SRC_WDT, csdc_pkg::RNG_LOW, 8'h00, 1'h0, 1'h1, 10, 224, 1'h1};
        rows[1] = '{csdc_pkg::SRC_RC, csdc_pkg::RNG_MED, 8'h01, 1'h1, 1'h1, 6, 224, 1'h0};
        rows[2] = '{csdc_pkg::SRC_XTAL, csdc_pkg::RNG_LOW, 8'h03, 1'h0, 1'h1, 8, 992, 1'h0};
        rows[3] = '{csdc_pkg::SRC_XTAL, csdc_pkg::RNG_MED, 8'h00, 1'h0, 1'h0, 8, 992, 1'h0};
        rows[4] = '{csdc_pkg::SRC_XTAL, csdc_pkg::RNG_HIGH, 8'h02, 1'h0, 1'h1, 8, 992, 1'h0};
        rows[5] = '{csdc_pkg::SRC_EXT, csdc_pkg::RNG_HIGH, 8'hff, 1'h0, 1'h1, 8, 224, 1'h1};
        n_fail = 0;
        cmp_count = 0;
        rst = 1'h1;
        por = 1'h1;
        trim_we = 1'h0;
        lp_we = 1'h0;
        lp_wdata = 1'h0;
        rtc_on_xtal = 1'h0;
        factory_trim = 6'h2a;
        cpu_clock_divider = 8'h00;
        trim_wdata = '0;
        cfg = '{src: csdc_pkg::SRC_RC, range: csdc_pkg::RNG_LOW};
        wait_clk(1);
        foreach (rows[i])
        begin
            cfg = '{src: rows[i].src, range: rows[i].rng};
            cpu_clock_divider = rows[i].div_n;
            rtc_on_xtal = rows[i].rtc;
            do_reset(1'h1);
            write_trim(rows[i].en, 6'h15);
            wake(rows[i].per, rows[i].wake);
            chk_bit(xtal_amp_en, rows[i].src == csdc_pkg::SRC_XTAL, "amp enable");
            if (rows[i].src == csdc_pkg::SRC_XTAL)
                chk_val(8'(xtal_range), 8'(rows[i].rng), "xtal range");
            measure(rows[i].div_n == 0 ? rows[i].per : 2 * rows[i].div_n * rows[i].per,
                rows[i].oe);
        end
        // trim load only on power-on, low power bit cleared on any reset
        cfg = '{src: csdc_pkg::SRC_RC, range: csdc_pkg::RNG_LOW};
        cpu_clock_divider = 8'h02;
        rtc_on_xtal = 1'h0;
        do_reset(1'h1);
        chk_val(8'(trim_q), 8'h2a, "trim after power-on");
        write_trim(1'h1, 6'h15);
        lp_we = 1'h1;
        lp_wdata = 1'h1;
        wait_clk(1);
        lp_we = 1'h0;
        chk_val(8'(trim_q), 8'h55, "trim written");
        chk_bit(low_power_clock_bit, 1'h1, "lp written");
        do_reset(1'h0);
        chk_val(8'(trim_q), 8'h55, "trim kept on reset");
        wake(6, 224);
        // late config change ignored, divider change while running
        cfg = '{src: csdc_pkg::SRC_XTAL, range: csdc_pkg::RNG_HIGH};
        measure(24, 1'h1);
        chk_bit(xtal_amp_en, 1'h0, "amp after late config");
        wait_tick();
        wait_clk(5);
        cpu_clock_divider = 8'h04;
        wait_tick();
        measure(48, 1'h1);
        chk_bit(cpu_run, 1'h1, "run after divider change");
        write_trim(1'h0, 6'h15);
        measure(48, 1'h0);
        results();
    end
endmodule : clock_source_divider_control_tb_top
